/* hdl/asc_defines.svh */
// Constants for the serial converter control link and its two ends.
// Assumes a 125 MHz system clock on both ends.
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH

`define ASC_CLK_PERIOD_NS 8
`define ASC_WORD_BITS 5
`define ASC_CHAN_MSB 4
`define ASC_CHAN_LSB 2
`define ASC_SOFT_CONVERT_BIT 1
`define ASC_POWER_DOWN_REQUEST_BIT 0
`define ASC_WORD_RESET 5'h00
`define ASC_COMMIT_EDGE 3'h5
`define ASC_POWER_DOWN_REQUEST_EDGE 3'h6
`define ASC_PULSES_WRITE 3'h6
`define ASC_PULSES_POWER_DOWN_REQUEST 3'h7
`define ASC_SOFT_CONVERT_TIME_NS 5900
`define ASC_SOFT_CONVERT_CYCLES ((`ASC_SOFT_CONVERT_TIME_NS + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`define ASC_ACQ_TIME_NS 2000
`define ASC_GAP_CYCLES ((`ASC_SOFT_CONVERT_TIME_NS + `ASC_ACQ_TIME_NS + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`define ASC_SETTLE_CYCLES 250
`define ASC_SCLK_HALF 10'h008
`define ASC_REG_CTRL 32'h0000_0000
`define ASC_REG_STATUS 32'h0000_0004
`define ASC_RESP_OKAY 2'h0
`define ASC_RESP_SLVERR 2'h2

`endif

/* hdl/asc_device.sv */
// Converter control logic: serial control word, settling pulse, starts.
// Assumes the link clock only runs inside frames and idles low.
`timescale 1ns/100ps
`default_nettype none
`include "asc_defines.svh"

// Summary of operation
// - Hold five-bit word, channel bits on top
// - Host gives at least six clock pulses
// - Short frame leaves word unchanged
// - Soft start works however long frame lasts
// - Word clears to zero at reset
// - Channel bits form binary channel number
// - Address write launches settling; blocks conversion
// - Settling end starts pending conversion
// - Soft start after sixth serial clock
// - Stored soft bit disables hardware start
// - Stored soft bit never repeats conversions
// - Standby bit selects power-down or normal
// - Standby taken on seventh falling edge
// - Host waits acquisition time between conversions
// - Hardware rising edge starts if settled
// - Settling starts at frame, discharges sixth edge
// - Conversion completes after fixed time
module asc_device
#(
	parameter int SETTLE_CYCLES = `ASC_SETTLE_CYCLES
)
(
	input wire logic sys_clk,
	input wire logic resetn,
	asc_link_if.dev link,
	input wire logic hw_convert_start_n,
	output logic [2:0] mux_channel,
	output logic settle_timer_cap,
	output logic track_hold_in_hold,
	output logic conversion_done,
	output logic power_down
);

	localparam logic [9:0] SOFT_CONVERT_CYCLES = 10'(`ASC_SOFT_CONVERT_CYCLES);
	localparam logic [11:0] SETTLE_LOAD = 12'(SETTLE_CYCLES);

	// Link clock domain, falling edges
	logic frame_rst_n;
	logic [2:0] edge_cnt_ff;
	logic [4:0] shift_ff;
	asc_pkg::asc_word_s word_ff;
	logic power_down_request_ff;
	logic commit_tgl_ff;

	// Counter is cleared by the frame sync itself, since the link
	// clock stops between frames and cannot do it.
	assign frame_rst_n = resetn & ~link.transmit_frame_sync_n;

	always_ff @(negedge link.serial_clk or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
			edge_cnt_ff <= 3'h0;
		else if (edge_cnt_ff != 3'h7)
			edge_cnt_ff <= edge_cnt_ff + 3'h1;
	end

	always_ff @(negedge link.serial_clk or negedge resetn)
	begin
		if (!resetn)
			shift_ff <= `ASC_WORD_RESET;
		else if (edge_cnt_ff < `ASC_COMMIT_EDGE)
			shift_ff <= {shift_ff[3:0], link.serial_data};
	end

	always_ff @(negedge link.serial_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			word_ff <= `ASC_WORD_RESET;
			commit_tgl_ff <= 1'b0;
		end
		else if (edge_cnt_ff == `ASC_COMMIT_EDGE)
		begin
			// Only a sixth edge commits; shorter frames change nothing
			word_ff <= shift_ff;
			commit_tgl_ff <= ~commit_tgl_ff;
		end
	end

	always_ff @(negedge link.serial_clk or negedge resetn)
	begin
		if (!resetn)
			power_down_request_ff <= 1'b0;
		else if (edge_cnt_ff == `ASC_POWER_DOWN_REQUEST_EDGE)
			power_down_request_ff <= shift_ff[`ASC_POWER_DOWN_REQUEST_BIT];
		// Leaving standby needs only a six-edge write; entering waits
		// for the seventh edge
		else if (edge_cnt_ff == `ASC_COMMIT_EDGE && !shift_ff[`ASC_POWER_DOWN_REQUEST_BIT])
			power_down_request_ff <= 1'b0;
	end

	// System clock domain
	logic [1:0] tfs_sync_ff;
	logic [1:0] commit_sync_ff;
	logic commit_prev_ff;
	logic [1:0] power_down_request_sync_ff;
	logic [1:0] hw_sync_ff;
	logic hw_prev_ff;
	logic commit_evt;
	logic hw_rise;
	logic tfs_low;

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			tfs_sync_ff <= 2'h3;
			commit_sync_ff <= 2'h0;
			commit_prev_ff <= 1'b0;
			power_down_request_sync_ff <= 2'h0;
			hw_sync_ff <= 2'h3;
			hw_prev_ff <= 1'b1;
		end
		else
		begin
			tfs_sync_ff <= {tfs_sync_ff[0], link.transmit_frame_sync_n};
			commit_sync_ff <= {commit_sync_ff[0], commit_tgl_ff};
			commit_prev_ff <= commit_sync_ff[1];
			power_down_request_sync_ff <= {power_down_request_sync_ff[0], power_down_request_ff};
			hw_sync_ff <= {hw_sync_ff[0], hw_convert_start_n};
			hw_prev_ff <= hw_sync_ff[1];
		end
	end

	assign commit_evt = commit_sync_ff[1] ^ commit_prev_ff;
	assign hw_rise = hw_sync_ff[1] & ~hw_prev_ff;
	assign tfs_low = ~tfs_sync_ff[1];

	// The committed word is stable for at least six link clocks after
	// its toggle, far longer than the three-cycle crossing.
	logic [2:0] channel_ff;
	logic soft_convert_bit_ff;

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			channel_ff <= 3'h0;
			soft_convert_bit_ff <= 1'b0;
		end
		else if (commit_evt)
		begin
			channel_ff <= word_ff.channel;
			soft_convert_bit_ff <= word_ff.soft_convert;
		end
	end

	assign mux_channel = channel_ff;

	logic power_down_ff;

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			power_down_ff <= 1'b0;
		else
			power_down_ff <= power_down_request_sync_ff[1];
	end

	assign power_down = power_down_ff;

	// Settling pulse: held while a frame is open and not yet committed,
	// then timed down from the commit.
	logic frame_done_ff;
	logic [11:0] settle_cnt_ff;
	logic settle_reload;
	logic settle_active;
	logic settle_out_ff;

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			frame_done_ff <= 1'b0;
		else if (commit_evt)
			frame_done_ff <= 1'b1;
		else if (!tfs_low)
			frame_done_ff <= 1'b0;
	end

	assign settle_reload = tfs_low & ~frame_done_ff & ~commit_evt;

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			settle_cnt_ff <= 12'h000;
		else if (settle_reload)
			settle_cnt_ff <= SETTLE_LOAD;
		else if (settle_cnt_ff != 12'h000)
			settle_cnt_ff <= settle_cnt_ff - 12'h001;
	end

	assign settle_active = settle_reload | (settle_cnt_ff != 12'h000);

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			settle_out_ff <= 1'b0;
		else
			settle_out_ff <= settle_active;
	end

	assign settle_timer_cap = settle_out_ff;

	// Conversion start and timing
	logic pending_ff;
	logic [9:0] soft_convert_cnt_ff;
	logic busy;
	logic start;
	logic done_ff;

	assign busy = soft_convert_cnt_ff != 10'h000;
	// A hardware edge seen while settling or disabled is dropped
	assign start = ~busy & ~settle_active & ~power_down_ff &
		(pending_ff | (hw_rise & ~soft_convert_bit_ff));

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			pending_ff <= 1'b0;
		else if (commit_evt && word_ff.soft_convert)
			pending_ff <= 1'b1;
		else if (start)
			pending_ff <= 1'b0;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			soft_convert_cnt_ff <= 10'h000;
		else if (start)
			soft_convert_cnt_ff <= SOFT_CONVERT_CYCLES;
		else if (busy)
			soft_convert_cnt_ff <= soft_convert_cnt_ff - 10'h001;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			track_hold_in_hold <= 1'b0;
			done_ff <= 1'b0;
		end
		else
		begin
			track_hold_in_hold <= start | (soft_convert_cnt_ff > 10'h001);
			done_ff <= soft_convert_cnt_ff == 10'h001;
		end
	end

	assign conversion_done = done_ff;

endmodule

`default_nettype wire

/* hdl/asc_host.sv */
// Host controller: AXI4-Lite command registers driving the serial link.
// Assumes the device samples data on falling serial clock edges.
`timescale 1ns/100ps
`default_nettype none
`include "asc_defines.svh"

module asc_host
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	asc_link_if.host link
);

	localparam logic [9:0] GAP_CYCLES = 10'(`ASC_GAP_CYCLES);

	asc_pkg::asc_host_st_e state_ff;
	logic go_ff;
	logic [31:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic wstrb0_ff;
	logic aw_got_ff;
	logic w_got_ff;
	logic [4:0] last_word_ff;

	function automatic logic is_reg(input logic [31:0] a, input logic [31:0] r);
		is_reg = a == r;
	endfunction

	// Write channel; a command written while a frame runs is dropped
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ASC_RESP_OKAY;
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			awaddr_ff <= 32'h0000_0000;
			wdata_ff <= 32'h0000_0000;
			wstrb0_ff <= 1'b0;
			go_ff <= 1'b0;
		end
		else
		begin
			go_ff <= 1'b0;
			if (s_axi_awvalid && s_axi_awready)
			begin
				awaddr_ff <= s_axi_awaddr;
				aw_got_ff <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wdata_ff <= s_axi_wdata;
				wstrb0_ff <= s_axi_wstrb[0];
				w_got_ff <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (aw_got_ff && w_got_ff && !s_axi_bvalid)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= is_reg(awaddr_ff, `ASC_REG_CTRL) ?
					`ASC_RESP_OKAY : `ASC_RESP_SLVERR;
				go_ff <= is_reg(awaddr_ff, `ASC_REG_CTRL) && wstrb0_ff &&
					state_ff == asc_pkg::ASC_IDLE;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `ASC_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `ASC_RESP_OKAY;
			if (is_reg(s_axi_araddr, `ASC_REG_CTRL))
				s_axi_rdata <= {27'h0, last_word_ff};
			else if (is_reg(s_axi_araddr, `ASC_REG_STATUS))
				s_axi_rdata <= {31'h0, state_ff != asc_pkg::ASC_IDLE};
			else
			begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= `ASC_RESP_SLVERR;
			end
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Serial frame engine; the link clock is a divided system clock
	logic [9:0] div_ff;
	logic [2:0] pulses_ff;
	logic [2:0] npulse_ff;
	logic [4:0] shift_ff;
	logic sclk_ff;
	logic tfs_n_ff;
	logic sdata_ff;
	logic half_done;

	assign half_done = div_ff == `ASC_SCLK_HALF - 10'h001;

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_ff <= asc_pkg::ASC_IDLE;
			div_ff <= 10'h000;
			pulses_ff <= 3'h0;
			npulse_ff <= `ASC_PULSES_WRITE;
			shift_ff <= `ASC_WORD_RESET;
			last_word_ff <= `ASC_WORD_RESET;
			sclk_ff <= 1'b0;
			tfs_n_ff <= 1'b1;
			sdata_ff <= 1'b0;
		end
		else
		begin
			div_ff <= div_ff + 10'h001;
			case (state_ff)
				asc_pkg::ASC_IDLE:
				begin
					div_ff <= 10'h000;
					if (go_ff)
					begin
						shift_ff <= wdata_ff[4:0];
						last_word_ff <= wdata_ff[4:0];
						npulse_ff <= wdata_ff[`ASC_POWER_DOWN_REQUEST_BIT] ?
							`ASC_PULSES_POWER_DOWN_REQUEST : `ASC_PULSES_WRITE;
						pulses_ff <= 3'h0;
						tfs_n_ff <= 1'b0;
						state_ff <= asc_pkg::ASC_LEAD;
					end
				end
				asc_pkg::ASC_LEAD, asc_pkg::ASC_PULSE:
				begin
					if (half_done)
					begin
						div_ff <= 10'h000;
						sclk_ff <= ~sclk_ff;
						state_ff <= asc_pkg::ASC_PULSE;
						if (!sclk_ff)
						begin
							sdata_ff <= shift_ff[4];
							shift_ff <= {shift_ff[3:0], 1'b0};
						end
						else
						begin
							pulses_ff <= pulses_ff + 3'h1;
							// Frame always runs to full length, so
							// no partial write needs restarting
							if (pulses_ff + 3'h1 == npulse_ff)
								state_ff <= asc_pkg::ASC_TAIL;
						end
					end
				end
				asc_pkg::ASC_TAIL:
				begin
					if (half_done)
					begin
						div_ff <= 10'h000;
						tfs_n_ff <= 1'b1;
						sdata_ff <= 1'b0;
						state_ff <= asc_pkg::ASC_GAP;
					end
				end
				asc_pkg::ASC_GAP:
				begin
					// Covers conversion plus acquisition before next frame
					if (div_ff == GAP_CYCLES)
						state_ff <= asc_pkg::ASC_IDLE;
				end
				default:
					state_ff <= asc_pkg::ASC_IDLE;
			endcase
		end
	end

	assign link.serial_clk = sclk_ff;
	assign link.transmit_frame_sync_n = tfs_n_ff;
	assign link.serial_data = sdata_ff;

endmodule

`default_nettype wire

/* hdl/asc_link_if.sv */
// Serial write link between host controller and converter control logic.
// The host drives all three wires; the serial clock idles low.
`timescale 1ns/100ps
`default_nettype none

interface asc_link_if;
	logic serial_clk;
	logic transmit_frame_sync_n;
	logic serial_data;

	modport host
	(
		output serial_clk,
		output transmit_frame_sync_n,
		output serial_data
	);

	modport dev
	(
		input serial_clk,
		input transmit_frame_sync_n,
		input serial_data
	);
endinterface

`default_nettype wire

/* hdl/asc_pkg.sv */
// Types shared by the converter control link ends.
// Assumes asc_defines.svh gives the field positions.
package asc_pkg;

	typedef struct packed {
		logic [2:0] channel;
		logic soft_convert;
		logic power_down_request;
	} asc_word_s;

	typedef enum logic [2:0] {
		ASC_IDLE = 3'h0,
		ASC_LEAD = 3'h1,
		ASC_PULSE = 3'h3,
		ASC_TAIL = 3'h2,
		ASC_GAP = 3'h6
	} asc_host_st_e;

endpackage

/* test/asc_link_props.sv */
// Checks on the first link and on the outputs of the device it feeds.
// Assumes sys_clk is fast enough to see every link clock edge.
`timescale 1ns/100ps
`default_nettype none

module asc_link_props
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic serial_clk,
	input wire logic transmit_frame_sync_n,
	input wire logic serial_data,
	input wire logic [2:0] mux_channel,
	input wire logic settle_timer_cap,
	input wire logic track_hold_in_hold,
	input wire logic conversion_done,
	input wire logic power_down
);
	logic sclk_ff;
	logic tfs_ff;
	logic [3:0] fall_cnt_ff;
	logic [10:0] hold_cnt_ff;
	logic [8:0] acq_cnt_ff;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sclk_ff <= 1'b0;
			tfs_ff <= 1'b1;
		end
		else
		begin
			sclk_ff <= serial_clk;
			tfs_ff <= transmit_frame_sync_n;
		end
	end

	// Kept past frame end: commits land a few cycles after the edge
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			fall_cnt_ff <= 4'h0;
		else if (tfs_ff && !transmit_frame_sync_n)
			fall_cnt_ff <= 4'h0;
		else if (sclk_ff && !serial_clk)
			fall_cnt_ff <= fall_cnt_ff + 4'h1;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			hold_cnt_ff <= 11'h000;
		else
			hold_cnt_ff <= track_hold_in_hold ? hold_cnt_ff + 11'h001 : 11'h000;
	end

	// Saturates so the first conversion after reset is never flagged
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			acq_cnt_ff <= 9'h1FF;
		else if (track_hold_in_hold)
			acq_cnt_ff <= 9'h000;
		else if (acq_cnt_ff != 9'h1FF)
			acq_cnt_ff <= acq_cnt_ff + 9'h001;
	end

	sequence frame_open_s;
		$fell(transmit_frame_sync_n);
	endsequence

	sequence frame_close_s;
		$rose(transmit_frame_sync_n);
	endsequence

	idle_clock_a: assert property (transmit_frame_sync_n && tfs_ff |-> !serial_clk)
		else $error("link clock runs outside a frame");
	min_pulses_a: assert property (frame_close_s |-> fall_cnt_ff >= 4'h6)
		else $error("frame closed with too few pulses");
	standby_edge_a: assert property ($rose(power_down) |-> fall_cnt_ff == 4'h7)
		else $error("standby entered without seventh edge");
	chan_commit_a: assert property ($changed(mux_channel) |-> fall_cnt_ff >= 4'h6)
		else $error("channel changed without a full write");
	settle_open_a: assert property (frame_open_s |-> ##[1:6] settle_timer_cap)
		else $error("settling pulse did not start at frame open");
	settle_block_a: assert property ($rose(track_hold_in_hold) |-> !settle_timer_cap)
		else $error("conversion started while settling");
	standby_block_a: assert property ($rose(track_hold_in_hold) |-> !power_down)
		else $error("conversion started in standby");
	soft_convert_length_a: assert property ($fell(track_hold_in_hold) |-> hold_cnt_ff == 11'h2E2)
		else $error("conversion length wrong");
	soft_convert_done_a: assert property ($fell(track_hold_in_hold) |-> ##[0:1] conversion_done)
		else $error("no done pulse at conversion end");
	bit_stable_a: assert property ($fell(serial_clk) |-> $stable(serial_data))
		else $error("data moved at sampling edge");
	acq_gap_a: assert property ($rose(track_hold_in_hold) |-> acq_cnt_ff >= 9'h0FA)
		else $error("conversion started before acquisition time");
endmodule

`default_nettype wire

/* test/asc_tb.sv */
// Bench: AXI4-Lite host drives device one; the bench drives device two.
// Assumes settling is shortened to four cycles in both devices.
`timescale 1ns/100ps
`default_nettype none
`include "asc_defines.svh"

module asc_tb;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic [31:0] awaddr, wdata, araddr, rdata, rval;
	logic [3:0] wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp;
	logic hw_n, settle, hold, done, pd, pd2;
	logic [2:0] mux, mux2;
	int failures = 0;
	int check_count = 0;
	int soft_convert_n = 0;
	int n;

	asc_link_if link();
	asc_link_if link2();

	asc_host asc_host_inst (.sys_clk(sys_clk), .resetn(resetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link.host));
	asc_device #(.SETTLE_CYCLES(4)) asc_device_inst (.sys_clk(sys_clk),
		.resetn(resetn), .link(link.dev), .hw_convert_start_n(hw_n),
		.mux_channel(mux), .settle_timer_cap(settle),
		.track_hold_in_hold(hold), .conversion_done(done), .power_down(pd));
	// Second device faces the bench so malformed frames can be sent
	asc_device #(.SETTLE_CYCLES(4)) asc_device_inst2 (.sys_clk(sys_clk),
		.resetn(resetn), .link(link2.dev), .hw_convert_start_n(1'b1),
		.mux_channel(mux2), .settle_timer_cap(), .track_hold_in_hold(),
		.conversion_done(), .power_down(pd2));
	asc_link_props asc_link_props_inst (.sys_clk(sys_clk), .resetn(resetn),
		.serial_clk(link.serial_clk),
		.transmit_frame_sync_n(link.transmit_frame_sync_n),
		.serial_data(link.serial_data), .mux_channel(mux),
		.settle_timer_cap(settle), .track_hold_in_hold(hold),
		.conversion_done(done), .power_down(pd));

	always #4 sys_clk = ~sys_clk;

	always @(posedge sys_clk)
		if (done === 1'b1)
			soft_convert_n <= soft_convert_n + 1;

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		bready <= 1'b0;
		check({30'h0, bresp}, {30'h0, er});
	endtask

	task automatic rd(input logic [31:0] a, input logic [1:0] er);
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		rval = rdata;
		rready <= 1'b0;
		check({30'h0, rresp}, {30'h0, er});
	endtask

	// Busy only shows after the command edge, so give it time first
	task automatic idle();
		repeat (4) @(posedge sys_clk);
		do
			rd(`ASC_REG_STATUS, `ASC_RESP_OKAY);
		while (rval[0] !== 1'b0);
	endtask

	task automatic hw_pulse();
		@(posedge sys_clk);
		hw_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		hw_n <= 1'b1;
		repeat (800) @(posedge sys_clk);
	endtask

	task automatic frame(input logic [4:0] w, input int pulses);
		link2.transmit_frame_sync_n = 1'b0;
		#100;
		for (int i = 0; i < pulses; i++)
		begin
			link2.serial_clk = 1'b1;
			link2.serial_data = (i < 5) ? w[4 - i] : 1'b0;
			#62.5;
			link2.serial_clk = 1'b0;
			#62.5;
		end
		#100;
		link2.transmit_frame_sync_n = 1'b1;
		link2.serial_data = ~link2.serial_data;
		#2000;
	endtask

	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		#400000;
		failures++;
		tally_and_finish();
	end

	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, wdata, araddr} = 96'h0;
		wstrb = 4'hF;
		hw_n = 1'b1;
		link2.serial_clk = 1'b0;
		link2.serial_data = 1'b0;
		link2.transmit_frame_sync_n = 1'b1;
		repeat (8) @(posedge sys_clk);
		resetn <= 1'b1;
		rd(`ASC_REG_CTRL, `ASC_RESP_OKAY);
		check(rval, 32'h0);
		check({26'h0, settle, hold, pd, mux}, 32'h0);
		for (int c = 0; c < 8; c++)
		begin
			wr(`ASC_REG_CTRL, c << 2, `ASC_RESP_OKAY);
			idle();
			check({29'h0, mux}, c);
			rd(`ASC_REG_CTRL, `ASC_RESP_OKAY);
			check(rval, c << 2);
		end
		n = soft_convert_n;
		wr(`ASC_REG_CTRL, 32'h16, `ASC_RESP_OKAY);
		idle();
		check(soft_convert_n, n + 1);
		hw_pulse();
		check(soft_convert_n, n + 1);
		wr(`ASC_REG_CTRL, 32'h14, `ASC_RESP_OKAY);
		idle();
		check(soft_convert_n, n + 1);
		hw_pulse();
		check(soft_convert_n, n + 2);
		wr(`ASC_REG_CTRL, 32'h09, `ASC_RESP_OKAY);
		idle();
		check({31'h0, pd}, 32'h1);
		hw_pulse();
		check(soft_convert_n, n + 2);
		wr(`ASC_REG_CTRL, 32'h08, `ASC_RESP_OKAY);
		idle();
		check({31'h0, pd}, 32'h0);
		// A write without its low byte lane must leave the word alone
		wstrb <= 4'hE;
		wr(`ASC_REG_CTRL, 32'h1C, `ASC_RESP_OKAY);
		wstrb <= 4'hF;
		idle();
		rd(`ASC_REG_CTRL, `ASC_RESP_OKAY);
		check(rval, 32'h08);
		check({29'h0, mux}, 32'h2);
		wr(32'h0000_0008, 32'h1F, `ASC_RESP_SLVERR);
		rd(32'h0000_000C, `ASC_RESP_SLVERR);
		frame(5'h1C, 6);
		check({29'h0, mux2}, 32'h7);
		frame(5'h08, 3);
		check({29'h0, mux2}, 32'h7);
		frame(5'h01, 6);
		check({31'h0, pd2}, 32'h0);
		frame(5'h01, 7);
		check({31'h0, pd2}, 32'h1);
		tally_and_finish();
	end
endmodule

`default_nettype wire
